/* hw/trace_debug_regs.svh */
// register selector codes, field positions, reset values and trace codes for the trace/debug block
`ifndef TRACE_DEBUG_REGS_SVH
`define TRACE_DEBUG_REGS_SVH
`define SEL_CONFIG_STATUS      5'h00
`define SEL_ADDR_ATTR_TRIGGER  5'h06
`define SEL_TRIGGER_DEF        5'h07
`define SEL_PC_BREAKPOINT      5'h08
`define SEL_PC_BREAKPOINT_MASK 5'h09
`define SEL_ADDR_BP_HIGH       5'h0C
`define SEL_ADDR_BP_LOW        5'h0D
`define SEL_DATA_BREAKPOINT    5'h0E
`define SEL_DATA_BP_MASK       5'h0F
`define RST_CONFIG_STATUS      32'h00100000
`define RST_ADDR_ATTR_TRIGGER  32'h00000005
`define RST_TRIGGER_DEF        32'h00000000
`define RST_OTHER              32'h00000000
`define CSR_INHIBIT_BIT        22
`define CSR_BYTES_LO           8
`define CSR_BYTES_HI           9
`define PST_CONTINUE           4'h0
`define PST_BEGIN              4'h1
`define PST_TAKEN_BRANCH       4'h5
`define PST_MARKER_BASE        4'h8
`define TRACE_FIFO_DEPTH       8
`endif

/* hw/trace_debug_pkg.sv */
// types shared by the trace/debug block
package trace_debug_pkg;
    // one instruction retired by the core this cycle
    typedef struct packed {
        logic        valid;
        logic        taken;
        logic        variant;
        logic [31:0] target;
    } retire_t;
    // one register access from either path
    typedef struct packed {
        logic        write;
        logic        read;
        logic [4:0]  sel;
        logic [31:0] data;
    } reg_access_t;
    // background memory command side effect
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [31:0] addr;
        logic [31:0] data;
    } mem_cmd_t;
    typedef enum logic [1:0] {
        TR_IDLE,
        TR_MARKER,
        TR_STALL
    } trace_state_t;
endpackage

/* hw/nibble_fifo.sv */
// small synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module nibble_fifo #(
    parameter int WIDTH = 4,
    parameter int DEPTH = 4
) (
    input  wire logic             clock,
    input  wire logic             rstn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    // refuse sizes the pointer wrap cannot serve
    if (DEPTH < 2 || WIDTH < 1) begin : g_bad_size
        $error("nibble_fifo: bad size");
    end
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    // honest flags straight from the count
    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // storage
    always_ff @(posedge clock) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    // pointers and fill count
    always_ff @(posedge clock) begin
        if (!rstn) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + AW'(1);
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + AW'(1);
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

/* hw/branch_trace_debug.sv */
// taken-branch real-time trace and debug register file
`timescale 1ns/100ps
`include "trace_debug_regs.svh"

//
// Contract
// - a taken branch shows status code 0x5 in its cycle; the code shows it one clock after the retire, but drops a branch retiring in the marker cycle.
// - branch status, then optional byte-count marker, then address nibbles.
// - capture targets only for variant-addressed taken branches and exception vectors.
// - address goes out least significant nibble first.
// - marker before the address tells how many bytes follow.
// - byte count is configurable as two, three or four.
// - two-byte marker 0x9 is followed by exactly four nibbles.
// - a FIFO lets status run ahead of address output.
// - full FIFO with new capture stalls the core showing 0x0.
// - nine debug registers beside background access to core state.
// - processor may write, never read, debug registers in supervisor mode.
// - inhibit bit set blocks processor writes to breakpoint registers.
// - every debug register is a 32-bit quantity.
// - config/status is write-only from processor, read/write from port.
// - five-bit selector; reserved codes map to no register.
// - attribute, high address and data registers double as port memory holders; the code loads only high address and data.
// - port memory access overwrites high address; port write overwrites data.
// - marker appears one clock before its data begins.
// - marker codes 0x8 to 0xB give one to four bytes.
module branch_trace_debug #(
    parameter int FIFO_DEPTH = `TRACE_FIFO_DEPTH
) (
    input  wire logic                         clock,
    input  wire logic                         rstn,
    input  wire trace_debug_pkg::retire_t     retire,
    input  wire logic                         core_exception,
    output logic                              core_stall,
    output logic [3:0]                        processor_status_code,
    output logic [3:0]                        trace_data_nibbles,
    input  wire trace_debug_pkg::reg_access_t port_access,
    input  wire trace_debug_pkg::reg_access_t cpu_access,
    input  wire logic                         cpu_supervisor,
    input  wire trace_debug_pkg::mem_cmd_t    port_mem_cmd,
    output logic [31:0]                       port_read_data,
    output logic                              port_read_valid
);
    // a whole 4-byte address must fit, and the free count is only five bits
    if (FIFO_DEPTH < 8 || FIFO_DEPTH > 16) begin : g_bad_depth
        $error("trace FIFO must hold a whole 4-byte address");
    end

    // ****************************************************************
    // debug register file
    // ****************************************************************
    logic [31:0] config_status_q;
    logic [31:0] addr_attr_trigger_q;
    logic [31:0] trigger_def_q;
    logic [31:0] pc_breakpoint_q;
    logic [31:0] pc_breakpoint_mask_q;
    logic [31:0] addr_bp_high_q;
    logic [31:0] addr_bp_low_q;
    logic [31:0] data_breakpoint_q;
    logic [31:0] data_bp_mask_q;
    logic        cpu_wr_ok;
    logic        cpu_bp_blocked;
    logic [4:0]  sel;
    logic [31:0] wd;
    logic        we;

    // is the selector one of the breakpoint registers
    function automatic logic is_breakpoint(input logic [4:0] sel);
        is_breakpoint = (sel >= `SEL_ADDR_ATTR_TRIGGER) && (sel <= `SEL_DATA_BP_MASK)
                        && (sel != 5'h0A) && (sel != 5'h0B);
    endfunction

    // processor writes need supervisor; inhibit locks out breakpoint writes
    assign cpu_bp_blocked = config_status_q[`CSR_INHIBIT_BIT] && is_breakpoint(cpu_access.sel);
    assign cpu_wr_ok      = cpu_access.write && cpu_supervisor && !cpu_bp_blocked && !port_access.write;

    // one write port per register; port wins a same-cycle collision
    assign sel = port_access.write ? port_access.sel : cpu_access.sel;
    assign wd  = port_access.write ? port_access.data : cpu_access.data;
    assign we  = port_access.write || cpu_wr_ok;

    // register storage and shared-holder side effects
    always_ff @(posedge clock) begin
        if (!rstn) begin
            config_status_q      <= `RST_CONFIG_STATUS;
            addr_attr_trigger_q  <= `RST_ADDR_ATTR_TRIGGER;
            trigger_def_q        <= `RST_TRIGGER_DEF;
            pc_breakpoint_q      <= `RST_OTHER;
            pc_breakpoint_mask_q <= `RST_OTHER;
            addr_bp_high_q       <= `RST_OTHER;
            addr_bp_low_q        <= `RST_OTHER;
            data_breakpoint_q    <= `RST_OTHER;
            data_bp_mask_q       <= `RST_OTHER;
        end else begin
            if (we) begin
                // reserved selectors fall through and store nothing
                case (sel)
                    `SEL_CONFIG_STATUS:      config_status_q      <= wd;
                    `SEL_ADDR_ATTR_TRIGGER:  addr_attr_trigger_q  <= wd;
                    `SEL_TRIGGER_DEF:        trigger_def_q        <= wd;
                    `SEL_PC_BREAKPOINT:      pc_breakpoint_q      <= wd;
                    `SEL_PC_BREAKPOINT_MASK: pc_breakpoint_mask_q <= wd;
                    `SEL_ADDR_BP_HIGH:       addr_bp_high_q       <= wd;
                    `SEL_ADDR_BP_LOW:        addr_bp_low_q        <= wd;
                    `SEL_DATA_BREAKPOINT:    data_breakpoint_q    <= wd;
                    `SEL_DATA_BP_MASK:       data_bp_mask_q       <= wd;
                    default: ;
                endcase
            end
            // shared holders: memory commands clobber breakpoint values
            if (port_mem_cmd.valid) begin
                addr_bp_high_q <= port_mem_cmd.addr;
                if (port_mem_cmd.write) begin
                    data_breakpoint_q <= port_mem_cmd.data;
                end
            end
        end
    end

    // port reads only; processor has no read path at all
    always_ff @(posedge clock) begin
        if (!rstn) begin
            port_read_data  <= '0;
            port_read_valid <= 1'b0;
        end else begin
            port_read_valid <= port_access.read;
            if (port_access.read) begin
                case (port_access.sel)
                    `SEL_CONFIG_STATUS:      port_read_data <= config_status_q;
                    `SEL_ADDR_ATTR_TRIGGER:  port_read_data <= addr_attr_trigger_q;
                    `SEL_TRIGGER_DEF:        port_read_data <= trigger_def_q;
                    `SEL_PC_BREAKPOINT:      port_read_data <= pc_breakpoint_q;
                    `SEL_PC_BREAKPOINT_MASK: port_read_data <= pc_breakpoint_mask_q;
                    `SEL_ADDR_BP_HIGH:       port_read_data <= addr_bp_high_q;
                    `SEL_ADDR_BP_LOW:        port_read_data <= addr_bp_low_q;
                    `SEL_DATA_BREAKPOINT:    port_read_data <= data_breakpoint_q;
                    `SEL_DATA_BP_MASK:       port_read_data <= data_bp_mask_q;
                    default:                 port_read_data <= '0;
                endcase
            end
        end
    end

    // ****************************************************************
    // branch trace
    // ****************************************************************
    trace_debug_pkg::trace_state_t state_q;
    logic [31:0] target_q;
    logic [2:0]  bytes_q;
    logic [3:0]  nib_left_q;
    logic [2:0]  cfg_bytes;
    logic        capture;
    logic        fifo_in_ready;
    logic        fifo_out_valid;
    logic [3:0]  fifo_out_data;
    logic        push;
    logic [3:0]  push_nib;
    logic [4:0]  fifo_free_q;

    // byte count from config: 0 off, 1..3 select 2..4 bytes
    always_comb begin
        unique case (config_status_q[`CSR_BYTES_HI:`CSR_BYTES_LO])
            2'd1:    cfg_bytes = 3'd2;
            2'd2:    cfg_bytes = 3'd3;
            2'd3:    cfg_bytes = 3'd4;
            default: cfg_bytes = 3'd0;
        endcase
    end

    // only variant-addressed branches and exception vectors are captured
    assign capture = retire.valid && retire.taken && (retire.variant || core_exception)
                     && (cfg_bytes != 3'd0);

    // nibbles pushed one per clock from the address shifter
    assign push     = (nib_left_q != 4'd0);
    assign push_nib = target_q[3:0];

    // free-space tracker so a whole address is reserved before it is accepted
    always_ff @(posedge clock) begin
        if (!rstn) begin
            fifo_free_q <= 5'(FIFO_DEPTH);
        end else begin
            fifo_free_q <= fifo_free_q - 5'(push && fifo_in_ready) + 5'(fifo_out_valid);
        end
    end

    // sequencer: status, marker, stall
    always_ff @(posedge clock) begin
        if (!rstn) begin
            state_q               <= trace_debug_pkg::TR_IDLE;
            processor_status_code <= `PST_CONTINUE;
            core_stall            <= 1'b0;
            target_q              <= '0;
            bytes_q               <= '0;
            nib_left_q            <= '0;
        end else begin
            if (push && fifo_in_ready) begin
                target_q   <= {4'h0, target_q[31:4]};
                nib_left_q <= nib_left_q - 4'd1;
            end
            unique case (state_q)
                trace_debug_pkg::TR_IDLE: begin
                    core_stall <= 1'b0;
                    if (capture && (nib_left_q != 4'd0 || fifo_free_q < 5'({cfg_bytes, 1'b0}))) begin
                        state_q               <= trace_debug_pkg::TR_STALL;
                        core_stall            <= 1'b1;
                        processor_status_code <= `PST_CONTINUE;
                    end else if (retire.valid && retire.taken) begin
                        processor_status_code <= `PST_TAKEN_BRANCH;
                        if (capture) begin
                            state_q  <= trace_debug_pkg::TR_MARKER;
                            target_q <= retire.target;
                            bytes_q  <= cfg_bytes;
                            // count loaded now so the first nibble enters during the marker
                            nib_left_q <= {cfg_bytes, 1'b0};
                        end
                    end else begin
                        processor_status_code <= retire.valid ? `PST_BEGIN : `PST_CONTINUE;
                    end
                end
                trace_debug_pkg::TR_MARKER: begin
                    // marker one clock before the first nibble leaves
                    processor_status_code <= `PST_MARKER_BASE + {1'b0, bytes_q - 3'd1};
                    state_q               <= trace_debug_pkg::TR_IDLE;
                end
                trace_debug_pkg::TR_STALL: begin
                    processor_status_code <= `PST_CONTINUE;
                    if (nib_left_q == 4'd0 && fifo_free_q >= 5'({cfg_bytes, 1'b0})) begin
                        state_q               <= trace_debug_pkg::TR_MARKER;
                        processor_status_code <= `PST_TAKEN_BRANCH;
                        core_stall            <= 1'b0;
                        target_q              <= retire.target;
                        bytes_q               <= cfg_bytes;
                        nib_left_q            <= {cfg_bytes, 1'b0};
                    end
                end
            endcase
        end
    end

    // fifo decouples status from the address nibbles
    nibble_fifo #(
        .WIDTH (4),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clock     (clock),
        .rstn      (rstn),
        .in_valid  (push),
        .in_ready  (fifo_in_ready),
        .in_data   (push_nib),
        .out_valid (fifo_out_valid),
        .out_ready (1'b1),
        .out_data  (fifo_out_data)
    );

    // registered data port, zero when idle
    always_ff @(posedge clock) begin
        if (!rstn) begin
            trace_data_nibbles <= 4'h0;
        end else begin
            trace_data_nibbles <= fifo_out_valid ? fifo_out_data : 4'h0;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    // marker shows next cycle, low nibble of the captured target the cycle after
    sequence marker_then_nibble;
        ##1 (processor_status_code inside {[4'h9:4'hB]})
        ##1 (trace_data_nibbles == $past(target_q[3:0], 2));
    endsequence

    branch_code_a: assert property (@(posedge clock) disable iff (!rstn)
        (state_q == trace_debug_pkg::TR_IDLE && retire.valid && retire.taken && !capture)
        |=> processor_status_code == `PST_TAKEN_BRANCH)
        else $error("taken branch not shown as 0x5");
    marker_follows_a: assert property (@(posedge clock) disable iff (!rstn)
        $rose(state_q == trace_debug_pkg::TR_MARKER) |=> processor_status_code inside {[4'h9:4'hB]})
        else $error("marker missing after branch status");
    nibble_count_a: assert property (@(posedge clock) disable iff (!rstn)
        (state_q == trace_debug_pkg::TR_MARKER) |-> nib_left_q == {bytes_q, 1'b0})
        else $error("wrong nibble count for marker");
    stall_code_a: assert property (@(posedge clock) disable iff (!rstn)
        core_stall |-> processor_status_code == `PST_CONTINUE)
        else $error("stall not shown as continue");
    inhibit_lock_a: assert property (@(posedge clock) disable iff (!rstn)
        (cpu_access.write && !port_access.write && config_status_q[`CSR_INHIBIT_BIT]
         && cpu_access.sel == `SEL_DATA_BP_MASK && !port_mem_cmd.valid) |=> $stable(data_bp_mask_q))
        else $error("processor write passed the inhibit");
    user_write_a: assert property (@(posedge clock) disable iff (!rstn)
        (cpu_access.write && !cpu_supervisor && !port_access.write && cpu_access.sel == `SEL_TRIGGER_DEF)
        |=> $stable(trigger_def_q))
        else $error("user mode wrote a debug register");
    mem_clobber_a: assert property (@(posedge clock) disable iff (!rstn)
        port_mem_cmd.valid |=> addr_bp_high_q == $past(port_mem_cmd.addr))
        else $error("memory command did not load high address");
    reserved_read_a: assert property (@(posedge clock) disable iff (!rstn)
        (port_access.read && port_access.sel == 5'h03) |=> port_read_data == 32'h00000000)
        else $error("reserved selector returned data");
    marker_lead_a: assert property (@(posedge clock) disable iff (!rstn)
        (state_q == trace_debug_pkg::TR_MARKER && !fifo_out_valid) |-> marker_then_nibble)
        else $error("data not after marker");
endmodule

/* dv/trace_capture.sv */
// trace analyzer model rebuilding branch targets from status and trace nibbles
`timescale 1ns/100ps
module trace_capture (
    input wire logic       clock,
    input wire logic       rstn,
    input wire logic [3:0] processor_status_code,
    input wire logic [3:0] trace_data_nibbles
);
    logic [31:0] addr_q[$];
    logic [3:0]  mark_q[$];
    int          cnt_q[$];
    int          n_taken;
    int          got;
    logic [31:0] acc;
    // a zero nibble means an empty FIFO, so the bench keeps address nibbles nonzero
    always @(posedge clock) begin
        if (!rstn) begin
            n_taken = 0;
            got = 0;
            acc = '0;
        end else begin
            if (trace_data_nibbles != 4'h0 && cnt_q.size() > 0) begin
                acc[got*4 +: 4] = trace_data_nibbles;
                got++;
                if (got == cnt_q[0]) begin
                    addr_q.push_back(acc);
                    void'(cnt_q.pop_front());
                    got = 0;
                    acc = '0;
                end
            end
            if (processor_status_code == 4'h5)
                n_taken++;
            if (processor_status_code[3:2] == 2'b10) begin
                mark_q.push_back(processor_status_code);
                cnt_q.push_back((int'(processor_status_code) - 7) * 2);
            end
        end
    end
endmodule

/* dv/tb_top.sv */
// self-checking bench for the branch trace and debug register block
`timescale 1ns/100ps
`include "trace_debug_regs.svh"
module tb_top;
    logic                         clock;
    logic                         rstn;
    trace_debug_pkg::retire_t     retire;
    logic                         core_exception;
    logic                         core_stall;
    logic [3:0]                   processor_status_code;
    logic [3:0]                   trace_data_nibbles;
    trace_debug_pkg::reg_access_t port_access;
    trace_debug_pkg::reg_access_t cpu_access;
    logic                         cpu_supervisor;
    trace_debug_pkg::mem_cmd_t    port_mem_cmd;
    logic [31:0]                  port_read_data;
    logic                         port_read_valid;
    int                           n_fail;
    int                           compares;
    int                           seed;
    int                           n_br;
    logic                         saw_stall;
    logic [31:0]                  exp_q[$];
    logic [3:0]                   exp_m[$];
    logic [31:0]                  w[16];

    branch_trace_debug #(.FIFO_DEPTH(8)) dut_u (.clock(clock), .rstn(rstn), .retire(retire),
        .core_exception(core_exception), .core_stall(core_stall),
        .processor_status_code(processor_status_code), .trace_data_nibbles(trace_data_nibbles),
        .port_access(port_access), .cpu_access(cpu_access), .cpu_supervisor(cpu_supervisor),
        .port_mem_cmd(port_mem_cmd), .port_read_data(port_read_data), .port_read_valid(port_read_valid));
    trace_capture cap_u (.clock(clock), .rstn(rstn), .processor_status_code(processor_status_code),
        .trace_data_nibbles(trace_data_nibbles));

    // ****
    // helpers
    // ****
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic tally_and_finish;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // every nibble nonzero so the analyzer can tell data from an empty FIFO
    function automatic logic [31:0] rnd_t();
        return $random(seed) | 32'h11111111;
    endfunction

    task automatic preg(input logic wr, input logic [4:0] sel, input logic [31:0] d);
        @(negedge clock);
        port_access = {wr, !wr, sel, d};
        @(negedge clock);
        port_access = '0;
    endtask

    task automatic rd(input logic [4:0] sel, input logic [31:0] exp, input string what);
        int i;
        @(negedge clock);
        port_access = {1'b0, 1'b1, sel, 32'h0};
        // request stands one edge; the answer is valid the cycle after
        for (i = 0; i < 4; i++) begin
            @(negedge clock);
            port_access = '0;
            if (port_read_valid === 1'b1)
                break;
        end
        if (i == 4) begin
            n_fail++;
            tally_and_finish();
        end
        chk(what, port_read_data, exp);
    endtask

    // port side left idle meanwhile
    task automatic cwr(input logic sup, input logic [4:0] sel, input logic [31:0] d);
        @(negedge clock);
        cpu_supervisor = sup;
        cpu_access = {1'b1, 1'b0, sel, d};
        @(negedge clock);
        cpu_access = '0;
    endtask

    // retire held steady while the core is told to stall
    task automatic branch(input logic vb, input logic exc, input logic [31:0] t, input int cfg);
        int i;
        @(negedge clock);
        retire = {1'b1, 1'b1, vb, t};
        core_exception = exc;
        n_br++;
        if ((vb || exc) && cfg != 0) begin
            exp_q.push_back(cfg == 1 ? t & 32'hFFFF : cfg == 2 ? t & 32'hFFFFFF : t);
            exp_m.push_back(4'(8 + cfg));
        end
        for (i = 0; i < 50; i++) begin
            @(negedge clock);
            if (core_stall !== 1'b1)
                break;
            saw_stall = 1'b1;
            chk("stall status", processor_status_code, 4'h0);
        end
        if (i == 50) begin
            n_fail++;
            tally_and_finish();
        end
        retire = '0;
        core_exception = 1'b0;
    endtask

    // ****
    // main sequence
    // ****
    initial begin
        seed = 81751;
        {rstn, core_exception, cpu_supervisor, saw_stall} = '0;
        {retire, port_access, cpu_access, port_mem_cmd} = '0;
        {n_fail, compares, n_br} = '0;
        repeat (8) @(negedge clock);
        rstn = 1'b1;
        rd(`SEL_CONFIG_STATUS, `RST_CONFIG_STATUS, "csr reset");
        rd(`SEL_ADDR_ATTR_TRIGGER, `RST_ADDR_ATTR_TRIGGER, "attr reset");
        rd(`SEL_TRIGGER_DEF, `RST_TRIGGER_DEF, "trigger reset");
        // full-width write back; reserved selectors hold nothing
        for (int s = 1; s < 16; s++) begin
            w[s] = (s inside {[1:5], 10, 11}) ? 32'h0 : $random(seed);
            preg(1'b1, 5'(s), s < 6 || s > 9 && s < 12 ? 32'hFFFFFFFF : w[s]);
            rd(5'(s), w[s], "port write back");
        end
        cwr(1'b1, `SEL_PC_BREAKPOINT, ~w[8]);
        rd(`SEL_PC_BREAKPOINT, ~w[8], "cpu write");
        cwr(1'b0, `SEL_PC_BREAKPOINT, w[8]);
        rd(`SEL_PC_BREAKPOINT, ~w[8], "user write");
        @(negedge clock);
        cpu_access = {1'b0, 1'b1, 5'h00, 32'h0};
        @(negedge clock);
        cpu_access = '0;
        @(negedge clock);
        chk("cpu read", port_read_valid, 1'b0);
        cwr(1'b1, `SEL_CONFIG_STATUS, `RST_CONFIG_STATUS | (32'h1 << `CSR_INHIBIT_BIT));
        rd(`SEL_CONFIG_STATUS, `RST_CONFIG_STATUS | (32'h1 << `CSR_INHIBIT_BIT), "csr by cpu");
        cwr(1'b1, `SEL_DATA_BP_MASK, ~w[15]);
        rd(`SEL_DATA_BP_MASK, w[15], "locked write");
        // memory commands reuse the breakpoint holders
        @(negedge clock);
        port_mem_cmd = {1'b1, 1'b1, 32'h2468ACE0, 32'h9ABCDEF0};
        @(negedge clock);
        port_mem_cmd = {1'b1, 1'b0, 32'h13579BDF, 32'h0};
        @(negedge clock);
        port_mem_cmd = '0;
        rd(`SEL_ADDR_BP_HIGH, 32'h13579BDF, "memory address");
        rd(`SEL_DATA_BREAKPOINT, 32'h9ABCDEF0, "memory data");
        // trace off, then two, three and four bytes; bursts force a stall once trace is on
        for (int c = 0; c < 4; c++) begin
            preg(1'b1, `SEL_CONFIG_STATUS, `RST_CONFIG_STATUS | (32'(c) << `CSR_BYTES_LO));
            branch(1'b1, 1'b0, rnd_t(), c);
            branch(1'b0, 1'b1, rnd_t(), c);
            branch(1'b0, 1'b0, rnd_t(), c);
            repeat (20) @(negedge clock);
            repeat (3) branch(1'b1, 1'b0, rnd_t(), c);
            repeat (30) @(negedge clock);
        end
        chk("taken count", cap_u.n_taken, n_br);
        chk("address count", cap_u.addr_q.size(), exp_q.size());
        foreach (exp_q[k]) begin
            if (k < cap_u.addr_q.size()) begin
                chk("address", cap_u.addr_q[k], exp_q[k]);
                chk("marker", cap_u.mark_q[k], exp_m[k]);
            end
        end
        chk("stall seen", saw_stall, 1'b1);
        tally_and_finish();
    end
endmodule
